// ==== verilog/low_speed_8bit_timer.sv ====
`timescale 1ns/1ps
module low_speed_8bit_timer (
    input wire logic sys_clk_i, // System clock, 25 MHz
    input wire logic resetn_i, // Async reset, active low
    input wire logic low_speed_oscillator_i, // Count clock, asynchronous
    input wire logic [15:0] reg_addr_i, // Register byte address
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    output logic [7:0] reg_rdata_o, // Read data, cycle after strobe
    output logic irq_o // Level interrupt to the system
);
    import lso_timer_pkg::*;

    reg_req_t req;
    timer_ctl_t ctl_ff;
    logic [7:0] count_value_ff;
    logic [7:0] compare_value_ff;
    logic irq_enable_ff;
    logic irq_flag_ff;
    logic [7:0] rdata_ff;
    logic tick;
    logic step;
    logic match;
    logic wr_ctl;
    logic soft_clear;
    logic [7:0] nxt_count_value;

    // Address decode used by the write paths; the read path decodes with a case
    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        return a == ofs;
    endfunction

    assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

    lso_tick_sync u_tick (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .low_speed_oscillator_i(low_speed_oscillator_i),
        .tick_o(tick)
    );

    // Timer events
    assign step = tick & ctl_ff.run_control;
    assign match = count_value_ff == compare_value_ff;
    assign wr_ctl = req.wr & hit(req.addr, TIMER_CONTROL_OFS);
    assign soft_clear = wr_ctl & req.wdata[COUNTER_SOFT_CLEAR_POS];

    // Next count: soft clear beats a tick landing in the same cycle
    always_comb begin
        nxt_count_value = count_value_ff;
        if (soft_clear) begin
            nxt_count_value = COUNT_VALUE_RST;
        end else if (step) begin
            if (match) begin
                nxt_count_value = COUNT_VALUE_RST;
            end else begin
                nxt_count_value = count_value_ff + 8'h01;
            end
        end
    end

    // Counter; bus writes to it are ignored
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            count_value_ff <= COUNT_VALUE_RST;
        end else begin
            count_value_ff <= nxt_count_value;
        end
    end

    // Control; a software write wins over the one-shot stop in one cycle
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctl_ff <= TIMER_CTL_RST;
        end else if (wr_ctl) begin
            ctl_ff.run_control <= req.wdata[RUN_CONTROL_POS];
            ctl_ff.count_mode_select <= req.wdata[COUNT_MODE_SELECT_POS];
        end else if (step && match && ctl_ff.count_mode_select == MODE_ONE_SHOT) begin
            ctl_ff.run_control <= 1'b0;
        end
    end

    // Compare value
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            compare_value_ff <= COMPARE_VALUE_RST;
        end else if (req.wr && hit(req.addr, TIMER_COMPARE_VALUE_OFS)) begin
            compare_value_ff <= req.wdata;
        end
    end

    // Interrupt enable
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_enable_ff <= IRQ_ENABLE_RST;
        end else if (req.wr && hit(req.addr, TIMER_IRQ_ENABLE_OFS)) begin
            irq_enable_ff <= req.wdata[IRQ_BIT_POS];
        end
    end

    // Flag: a new event beats a write-one clear in the same cycle
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            irq_flag_ff <= IRQ_FLAG_RST;
        end else if (step && match) begin
            irq_flag_ff <= 1'b1;
        end else if (req.wr && hit(req.addr, TIMER_IRQ_FLAG_OFS) &&
                     req.wdata[IRQ_BIT_POS]) begin
            irq_flag_ff <= 1'b0;
        end
    end

    assign irq_o = irq_flag_ff & irq_enable_ff;

    // Read data, registered; unmapped and reserved bits read zero
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_ff <= READ_DATA_RST;
        end else if (req.rd) begin
            case (req.addr)
                TIMER_CONTROL_OFS: rdata_ff <= {6'h00, ctl_ff};
                TIMER_COUNT_VALUE_OFS: rdata_ff <= count_value_ff;
                TIMER_COMPARE_VALUE_OFS: rdata_ff <= compare_value_ff;
                TIMER_IRQ_ENABLE_OFS: rdata_ff <= {7'h00, irq_enable_ff};
                TIMER_IRQ_FLAG_OFS: rdata_ff <= {7'h00, irq_flag_ff};
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata_o = rdata_ff;

    // Checks
    property p_soft_clear;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        soft_clear |=> count_value_ff == 8'h00;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft clear missed");

    property p_mode_write;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        wr_ctl |=> ctl_ff.count_mode_select == $past(reg_wdata_i[1]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode bit not stored");

    property p_hold_stopped;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !ctl_ff.run_control && !soft_clear |=> $stable(count_value_ff);
    endproperty
    a_hold_stopped: assert property (p_hold_stopped) else $error("count moved stopped");

    property p_count_read;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        reg_rd_i && reg_addr_i == TIMER_COUNT_VALUE_OFS |=>
            reg_rdata_o == $past(count_value_ff);
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read wrong");

    property p_compare_write;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == TIMER_COMPARE_VALUE_OFS |=>
            compare_value_ff == $past(reg_wdata_i);
    endproperty
    a_compare_write: assert property (p_compare_write) else $error("compare not stored");

    property p_irq_gate;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == TIMER_IRQ_ENABLE_OFS && !reg_wdata_i[IRQ_BIT_POS] |=> !irq_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");

    property p_flag_set;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        step && match |=> irq_flag_ff;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set on match");

    property p_flag_clear;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == TIMER_IRQ_FLAG_OFS && reg_wdata_i[0] && !(step && match)
            |=> !irq_flag_ff;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_increment;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        step && !match && !soft_clear |=> count_value_ff == $past(count_value_ff) + 8'h01;
    endproperty
    a_increment: assert property (p_increment) else $error("count did not step");

    property p_one_shot_stop;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        step && match && ctl_ff.count_mode_select && !wr_ctl
            |=> !ctl_ff.run_control && count_value_ff == 8'h00;
    endproperty
    a_one_shot_stop: assert property (p_one_shot_stop) else $error("one-shot kept running");

    property p_repeat_runs;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        step && match && !ctl_ff.count_mode_select && !wr_ctl |=> ctl_ff.run_control;
    endproperty
    a_repeat_runs: assert property (p_repeat_runs) else $error("repeat mode stopped");

    // Setup registers change only on their own writes, except run, which the one-shot stop clears
    property p_run_write;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        wr_ctl |=> ctl_ff.run_control == $past(reg_wdata_i[RUN_CONTROL_POS]);
    endproperty
    a_run_write: assert property (p_run_write) else $error("run bit not stored");

    property p_mode_hold;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !wr_ctl |=> $stable(ctl_ff.count_mode_select);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode bit moved");

    // One-shot stop is the only hardware path that may touch run
    property p_run_hold;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !wr_ctl && !(step && match) |=> $stable(ctl_ff.run_control);
    endproperty
    a_run_hold: assert property (p_run_hold) else $error("run bit moved");

    property p_compare_hold;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !(reg_wr_i && reg_addr_i == TIMER_COMPARE_VALUE_OFS) |=> $stable(compare_value_ff);
    endproperty
    a_compare_hold: assert property (p_compare_hold) else $error("compare moved");

    property p_enable_write;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == TIMER_IRQ_ENABLE_OFS |=>
            irq_enable_ff == $past(reg_wdata_i[IRQ_BIT_POS]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not stored");

    property p_enable_hold;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !(reg_wr_i && reg_addr_i == TIMER_IRQ_ENABLE_OFS) |=> $stable(irq_enable_ff);
    endproperty
    a_enable_hold: assert property (p_enable_hold) else $error("enable moved");

    // Count moves only on a tick or a soft clear
    property p_count_ro;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        reg_wr_i && reg_addr_i == TIMER_COUNT_VALUE_OFS && !step |=> $stable(count_value_ff);
    endproperty
    a_count_ro: assert property (p_count_ro) else $error("count took a write");

    property p_count_idle;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !soft_clear && !step |=> $stable(count_value_ff);
    endproperty
    a_count_idle: assert property (p_count_idle) else $error("count moved idle");

    property p_wrap;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        step && match && !soft_clear |=> count_value_ff == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not restart");

    // A slow oscillator rise must give exactly one tick
    property p_tick_pulse;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        tick |=> !tick;
    endproperty
    a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");

    // Flag is sticky until a write of one, and never rises on its own
    property p_flag_sticky;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        irq_flag_ff &&
            !(reg_wr_i && reg_addr_i == TIMER_IRQ_FLAG_OFS && reg_wdata_i[IRQ_BIT_POS])
            |=> irq_flag_ff;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    property p_flag_quiet;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !irq_flag_ff && !(step && match) |=> !irq_flag_ff;
    endproperty
    a_flag_quiet: assert property (p_flag_quiet) else $error("flag set without event");

    property p_irq_on_event;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        step && match && irq_enable_ff && !(reg_wr_i && reg_addr_i == TIMER_IRQ_ENABLE_OFS)
            |=> irq_o;
    endproperty
    a_irq_on_event: assert property (p_irq_on_event) else $error("irq not raised");

    // Read paths: one-cycle data, zero otherwise
    property p_ctl_read;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        reg_rd_i && reg_addr_i == TIMER_CONTROL_OFS |=>
            reg_rdata_o == {6'h00, $past(ctl_ff)};
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("control read wrong");

    property p_clear_reads_zero;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        reg_rd_i && reg_addr_i == TIMER_CONTROL_OFS |=> !reg_rdata_o[COUNTER_SOFT_CLEAR_POS];
    endproperty
    a_clear_reads_zero: assert property (p_clear_reads_zero) else $error("clear bit read");

    property p_compare_read;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        reg_rd_i && reg_addr_i == TIMER_COMPARE_VALUE_OFS |=>
            reg_rdata_o == $past(compare_value_ff);
    endproperty
    a_compare_read: assert property (p_compare_read) else $error("compare read wrong");

    property p_enable_read;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        reg_rd_i && reg_addr_i == TIMER_IRQ_ENABLE_OFS |=>
            reg_rdata_o == {7'h00, $past(irq_enable_ff)};
    endproperty
    a_enable_read: assert property (p_enable_read) else $error("enable read wrong");

    property p_flag_read;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        reg_rd_i && reg_addr_i == TIMER_IRQ_FLAG_OFS |=>
            reg_rdata_o == {7'h00, $past(irq_flag_ff)};
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

    property p_rdata_idle;
        @(posedge sys_clk_i) disable iff (!resetn_i)
        !reg_rd_i |=> reg_rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

    c_match: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) step && match);
    c_one_shot: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        step && match && ctl_ff.count_mode_select);
    c_irq: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) $rose(irq_o));
    c_set_clear_race: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        step && match && reg_wr_i && reg_addr_i == TIMER_IRQ_FLAG_OFS);
    c_soft_clear: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) soft_clear);

endmodule // low_speed_8bit_timer

// ==== verilog/lso_timer_pkg.sv ====
package lso_timer_pkg;

    // Register map, byte addresses
    localparam logic [15:0] TIMER_CONTROL_OFS = 16'h50c0;
    localparam logic [15:0] TIMER_COUNT_VALUE_OFS = 16'h50c1;
    localparam logic [15:0] TIMER_COMPARE_VALUE_OFS = 16'h50c2;
    localparam logic [15:0] TIMER_IRQ_ENABLE_OFS = 16'h50c3;
    localparam logic [15:0] TIMER_IRQ_FLAG_OFS = 16'h50c4;

    // Field positions inside timer_control
    localparam int RUN_CONTROL_POS = 0;
    localparam int COUNT_MODE_SELECT_POS = 1;
    localparam int COUNTER_SOFT_CLEAR_POS = 4;
    // Field position inside the enable and flag registers
    localparam int IRQ_BIT_POS = 0;

    // Values after reset
    localparam logic [7:0] COUNT_VALUE_RST = 8'h00;
    localparam logic [7:0] COMPARE_VALUE_RST = 8'h00;
    localparam logic RUN_CONTROL_RST = 1'b0;
    localparam logic COUNT_MODE_SELECT_RST = 1'b0;
    localparam logic IRQ_ENABLE_RST = 1'b0;
    localparam logic IRQ_FLAG_RST = 1'b0;
    localparam logic [7:0] READ_DATA_RST = 8'h00;

    // Count mode encoding
    localparam logic MODE_REPEAT = 1'b0;
    localparam logic MODE_ONE_SHOT = 1'b1;

    // Control register as a carrier
    typedef struct packed {
        logic count_mode_select;
        logic run_control;
    } timer_ctl_t;

    localparam timer_ctl_t TIMER_CTL_RST = '{count_mode_select: COUNT_MODE_SELECT_RST,
                                             run_control: RUN_CONTROL_RST};

    // Register bus request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

endpackage

// ==== verilog/lso_tick_sync.sv ====
`timescale 1ns/1ps
// Brings the low-speed oscillator into sys_clk and marks each rising edge
module lso_tick_sync (
    input wire logic sys_clk_i, // System clock
    input wire logic resetn_i, // Async reset, active low
    input wire logic low_speed_oscillator_i, // Oscillator level, asynchronous
    output logic tick_o // One-cycle pulse per oscillator rise
);

    logic sync1_ff;
    logic sync2_ff;
    logic prev_ff;

    // Two-stage synchroniser plus history; only sync2 and prev feed the detector
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
            prev_ff <= 1'b0;
        end else begin
            sync1_ff <= low_speed_oscillator_i;
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    // Rising edge; oscillator must be well below sys_clk/2
    assign tick_o = sync2_ff & ~prev_ff;

endmodule // lso_tick_sync

// ==== dv/low_speed_8bit_timer_tb.sv ====
`timescale 1ns/1ps
module low_speed_8bit_timer_tb;
    import lso_timer_pkg::*;
    logic sys_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic osc_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000;
    logic [7:0] reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic irq_o;
    int errors = 0;
    int n_compared = 0;

    // 25 MHz system clock
    always #20 sys_clk_i = ~sys_clk_i;

    low_speed_8bit_timer u_low_speed_8bit_timer (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .low_speed_oscillator_i(osc_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o),
        .irq_o(irq_o)
    );

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // All tasks but chk start and end in the time step of a rising edge
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
        @(posedge sys_clk_i);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, e);
        @(posedge sys_clk_i);
    endtask

    task automatic irq_chk(input logic e);
        #1 chk({7'h00, irq_o}, {7'h00, e});
        @(posedge sys_clk_i);
    endtask

    // One oscillator period; high and low well above the 3-cycle minimum
    task automatic tick;
        osc_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        osc_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
    endtask

    task automatic t_reset_values;
        rd_chk(TIMER_CONTROL_OFS, 8'h00);
        rd_chk(TIMER_COUNT_VALUE_OFS, 8'h00);
        rd_chk(TIMER_COMPARE_VALUE_OFS, 8'h00);
        rd_chk(TIMER_IRQ_ENABLE_OFS, 8'h00);
        rd_chk(TIMER_IRQ_FLAG_OFS, 8'h00);
        rd_chk(16'h50c5, 8'h00);
        irq_chk(1'b0);
        $display("reset values done");
    endtask

    task automatic t_access;
        wr(TIMER_COMPARE_VALUE_OFS, 8'hff);
        rd_chk(TIMER_COMPARE_VALUE_OFS, 8'hff);
        wr(TIMER_COUNT_VALUE_OFS, 8'h55);
        rd_chk(TIMER_COUNT_VALUE_OFS, 8'h00);
        $display("register access done");
    endtask

    // Repeat mode wrap at compare 2, then stop holds the count
    task automatic t_repeat_run;
        wr(TIMER_COMPARE_VALUE_OFS, 8'h02);
        wr(TIMER_IRQ_ENABLE_OFS, 8'h01);
        wr(TIMER_CONTROL_OFS, 8'h01);
        tick();
        rd_chk(TIMER_COUNT_VALUE_OFS, 8'h01);
        tick();
        rd_chk(TIMER_COUNT_VALUE_OFS, 8'h02);
        rd_chk(TIMER_IRQ_FLAG_OFS, 8'h00);
        tick();
        rd_chk(TIMER_COUNT_VALUE_OFS, 8'h00);
        rd_chk(TIMER_IRQ_FLAG_OFS, 8'h01);
        irq_chk(1'b1);
        rd_chk(TIMER_CONTROL_OFS, 8'h01);
        tick();
        wr(TIMER_CONTROL_OFS, 8'h00);
        tick();
        rd_chk(TIMER_COUNT_VALUE_OFS, 8'h01);
        $display("repeat run done");
    endtask

    task automatic t_irq_gate;
        wr(TIMER_IRQ_ENABLE_OFS, 8'h00);
        irq_chk(1'b0);
        wr(TIMER_IRQ_ENABLE_OFS, 8'h01);
        irq_chk(1'b1);
        wr(TIMER_IRQ_FLAG_OFS, 8'h00);
        rd_chk(TIMER_IRQ_FLAG_OFS, 8'h01);
        wr(TIMER_IRQ_FLAG_OFS, 8'h01);
        rd_chk(TIMER_IRQ_FLAG_OFS, 8'h00);
        irq_chk(1'b0);
        $display("interrupt gating done");
    endtask

    task automatic t_soft_clear;
        wr(TIMER_CONTROL_OFS, 8'h01);
        tick();
        rd_chk(TIMER_COUNT_VALUE_OFS, 8'h02);
        wr(TIMER_CONTROL_OFS, 8'h11);
        rd_chk(TIMER_COUNT_VALUE_OFS, 8'h00);
        rd_chk(TIMER_CONTROL_OFS, 8'h01);
        $display("soft clear done");
    endtask

    // One-shot at compare 1 stops itself after the match
    task automatic t_one_shot;
        wr(TIMER_COMPARE_VALUE_OFS, 8'h01);
        wr(TIMER_CONTROL_OFS, 8'h13);
        tick();
        rd_chk(TIMER_COUNT_VALUE_OFS, 8'h01);
        tick();
        rd_chk(TIMER_COUNT_VALUE_OFS, 8'h00);
        rd_chk(TIMER_IRQ_FLAG_OFS, 8'h01);
        rd_chk(TIMER_CONTROL_OFS, 8'h02);
        tick();
        rd_chk(TIMER_COUNT_VALUE_OFS, 8'h00);
        $display("one shot done");
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        errors++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge sys_clk_i);
        resetn_i <= 1'b1;
        @(posedge sys_clk_i);
        t_reset_values();
        t_access();
        t_repeat_run();
        t_irq_gate();
        t_soft_clear();
        t_one_shot();
        end_sim();
    end
endmodule // low_speed_8bit_timer_tb
